/* File: include/tdpp_pkg.sv */
// constants and types shared by the tdm host port files
package tdpp_pkg;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned LOC_W  = 5;
  localparam int unsigned CNT_W  = 9;
  localparam int unsigned WR_W   = 1 + LOC_W + DATA_W;
  localparam int unsigned BUF_DEPTH = 2;
  // register space offsets (low five address bits)
  localparam logic [4:0] REG_CTRL1  = 5'h00;
  localparam logic [4:0] REG_CTRL2  = 5'h01;
  localparam logic [4:0] REG_VECTOR = 5'h02;
  localparam logic [4:0] REG_FLAGS1 = 5'h04;
  localparam logic [4:0] REG_FLAGS2 = 5'h05;
  localparam logic [4:0] REG_IMAGE1 = 5'h06;
  localparam logic [4:0] REG_IMAGE2 = 5'h07;
  localparam logic [4:0] REG_MASK1  = 5'h08;
  localparam logic [4:0] REG_MASK2  = 5'h09;
  localparam logic [4:0] REG_MATCH1 = 5'h0a;
  localparam logic [4:0] REG_MATCH2 = 5'h0b;
  localparam logic [4:0] REG_WATCH1 = 5'h0c;
  localparam logic [4:0] REG_WATCH2 = 5'h0d;
  // control_one field positions
  localparam int unsigned C1_IRQ_EN0   = 0;
  localparam int unsigned C1_IRQ_MODE0 = 2;
  localparam int unsigned C1_ADDR_EXT  = 4;
  localparam int unsigned C1_CH_COUNT  = 5;
  localparam int unsigned C1_IRQ_RST   = 6;
  // reset and fill values
  localparam logic [7:0]  REG_RESET  = 8'h00;
  localparam logic [7:0]  IDLE_BYTE  = 8'hff;
  localparam logic [20:0] PIN_IDLE   = 21'h1fc000;
  // serial timing: bit clock edge positions within a 16 edge channel slot
  localparam logic [3:0]  SLOT_PHASE = 4'he;
  localparam logic [3:0]  CH_START   = 4'h0;
  typedef enum logic [1:0] {ST_IDLE, ST_PUSH, ST_ACK} tdpp_host_st_t;
endpackage : tdpp_pkg

/* File: include/tdpp_buf_if.sv */
// valid/ready channel between the host port and its write buffer
`timescale 1ns/10ps
interface tdpp_buf_if #(parameter int unsigned WIDTH = 14);
  logic             in_valid;
  logic             in_ready;
  logic [WIDTH-1:0] in_data;
  logic             out_valid;
  logic             out_ready;
  logic [WIDTH-1:0] out_data;
  modport buffer (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
  modport user   (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
endinterface : tdpp_buf_if

/* File: design/tdpp_skid_buf.sv */
// small fifo holding posted host writes until the ram port is free
`timescale 1ns/10ps
module tdpp_skid_buf #(
  parameter int unsigned WIDTH = 14,
  parameter int unsigned DEPTH = 2
) (
  // clock and reset
  input wire logic   i_sys_clk,
  input wire logic   i_rst,
  // both sides of the buffer
  tdpp_buf_if.buffer bif
);
  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PW-1:0]    wr_ptr_reg;
  logic [PW-1:0]    rd_ptr_reg;
  logic [CW-1:0]    count_reg;
  logic             push;
  logic             pop;

  // honest full and empty from the fill count
  assign bif.in_ready  = (count_reg != CW'(DEPTH));
  assign bif.out_valid = (count_reg != '0);
  assign bif.out_data  = mem_reg[rd_ptr_reg];
  assign push = bif.in_valid && bif.in_ready;
  assign pop  = bif.out_valid && bif.out_ready;

  // storage and pointers
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        mem_reg[wr_ptr_reg] <= bif.in_data;
        wr_ptr_reg <= (wr_ptr_reg == PW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == PW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      count_reg <= count_reg + CW'(push) - CW'(pop);
    end
  end
endmodule : tdpp_skid_buf

/* File: design/tdpp_host_port.sv */
// peripheral-mode host port: channel rams, registers and tdm serial side
// Overview of operation
// - three 32 byte rams, 24 or 32 mode
// - select, read/write, strobe, acknowledge, irq, irq acknowledge
// - unmapped serial channels send all ones
// - low space: read receive, write first transmit
// - bit6 set: read receive, write second transmit
// - bit5 set: control one, two, vector
// - offsets 4-7 read flags, images; read-only
// - offsets 8,9 are mask registers
// - offsets 10,11 are match byte registers
// - offsets 12,13 name watched input channels
// - 24 mode skips every fourth channel
// - channel count bit: 0 gives 32, 1 gives 24
// - control one bit supplies address bit six
// - serial ram access wins; acknowledge held on reads, writes wait in the buffer
`timescale 1ns/10ps
module tdpp_host_port (
  // clock and reset
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst,
  // host strobe bus
  input  wire logic       i_chip_select_n,
  input  wire logic       i_read_write,
  input  wire logic       i_data_strobe_n,
  input  wire logic       i_interrupt_acknowledge_n,
  input  wire logic [5:0] i_address,
  input  wire logic [7:0] i_data,
  output logic      [7:0] o_data,
  output logic            o_data_oe,
  output logic            o_transfer_acknowledge_n,
  output logic            o_interrupt_request_n,
  // serial tdm link
  input  wire logic       i_serial_bit_clock,
  input  wire logic       i_frame_pulse_n,
  input  wire logic       i_serial_input_stream,
  output logic            o_serial_output_first,
  output logic            o_serial_output_second
);
  logic [20:0] pin_meta_reg;
  logic [20:0] pin_sync_reg;
  logic        cs_n_s, rw_s, ds_n_s, interrupt_acknowledge_n_n_s, c4_s, f0_n_s, sti_s;
  logic [5:0]  addr_s;
  logic [7:0]  data_s;
  logic [7:0]  ctrl1_reg, ctrl2_reg, vector_reg;
  logic [7:0]  mask_reg [2];
  logic [7:0]  match_reg [2];
  logic [7:0]  watch_reg [2];
  logic [7:0]  flags_reg [2];
  logic [7:0]  image_reg [2];
  logic [7:0]  prev_reg [2];
  logic [7:0]  rx_ram [32];
  logic [7:0]  tx_first_ram [32];
  logic [7:0]  tx_second_ram [32];
  logic        mode24;
  logic        c4_prev_reg, c4_fall, slot;
  logic [8:0]  cnt_reg;
  logic [4:0]  ch_now, ch_next;
  logic [7:0]  rx_sh_reg, rx_byte;
  logic [7:0]  hold_first_reg, hold_second_reg, sh_first_reg, sh_second_reg;
  logic        rx_ok, tx_ok;
  logic [4:0]  rx_loc, tx_loc;
  tdpp_pkg::tdpp_host_st_t state_reg;
  logic        host_req, vec_req, reg_wr, reg_rd, rd_conflict, drain_conflict;
  logic [4:0]  host_loc;
  logic [7:0]  reg_rd_val, dout_reg;
  logic        oe_reg, ack_n_reg, irq_n_reg;
  logic        wr_ext;
  logic [4:0]  wr_loc;
  logic [7:0]  wr_data;

  tdpp_buf_if #(.WIDTH(tdpp_pkg::WR_W)) bif ();

  // every pin input passes two flip-flops
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      pin_meta_reg <= tdpp_pkg::PIN_IDLE;
      pin_sync_reg <= tdpp_pkg::PIN_IDLE;
    end else begin
      pin_meta_reg <= {i_chip_select_n, i_read_write, i_data_strobe_n,
                       i_interrupt_acknowledge_n, i_serial_bit_clock, i_frame_pulse_n,
                       i_serial_input_stream, i_address, i_data};
      pin_sync_reg <= pin_meta_reg;
    end
  end
  assign {cs_n_s, rw_s, ds_n_s, interrupt_acknowledge_n_n_s, c4_s, f0_n_s, sti_s, addr_s, data_s} = pin_sync_reg;

  // ram location of a serial channel; 24 mode drops every fourth
  function automatic logic [5:0] loc_of(input logic [4:0] ch, input logic m24);
    logic [4:0] base;
    base = {ch[4:2], 1'b0} + {2'b00, ch[4:2]};
    if (!m24) begin
      loc_of = {1'b1, ch};
    end else begin
      loc_of = {ch[1:0] != 2'b00, base + {3'b000, ch[1:0]} - 5'd1};
    end
  endfunction : loc_of

  assign mode24 = ctrl1_reg[tdpp_pkg::C1_CH_COUNT];
  assign ch_now  = cnt_reg[8:4];
  assign ch_next = ch_now + 5'd1;
  assign {rx_ok, rx_loc} = loc_of(ch_now, mode24);
  assign {tx_ok, tx_loc} = loc_of(ch_next, mode24);
  assign c4_fall = c4_prev_reg && !c4_s;
  assign slot    = c4_fall && (cnt_reg[3:0] == tdpp_pkg::SLOT_PHASE);
  assign rx_byte = {rx_sh_reg[6:0], sti_s};

  // bit clock edge counter, restarted by the frame pulse
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      c4_prev_reg <= 1'b1;
      cnt_reg     <= '0;
      rx_sh_reg   <= '0;
    end else begin
      c4_prev_reg <= c4_s;
      if (c4_fall) begin
        cnt_reg <= !f0_n_s ? '0 : cnt_reg + 9'd1;
        if (cnt_reg[0] == 1'b0) begin
          rx_sh_reg <= rx_byte; // mid-bit sample
        end
      end
    end
  end

  // serial ram slot: store received byte, fetch next transmit bytes
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      hold_first_reg  <= tdpp_pkg::IDLE_BYTE;
      hold_second_reg <= tdpp_pkg::IDLE_BYTE;
    end else if (slot) begin
      if (rx_ok) begin
        rx_ram[rx_loc] <= rx_byte;
      end
      hold_first_reg  <= tx_ok ? tx_first_ram[tx_loc] : tdpp_pkg::IDLE_BYTE;
      hold_second_reg <= tx_ok ? tx_second_ram[tx_loc] : tdpp_pkg::IDLE_BYTE;
    end
  end

  // transmit shifters, msb first, new bit at each bit cell start
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      sh_first_reg           <= tdpp_pkg::IDLE_BYTE;
      sh_second_reg          <= tdpp_pkg::IDLE_BYTE;
      o_serial_output_first  <= 1'b1;
      o_serial_output_second <= 1'b1;
    end else if (c4_fall && cnt_reg[0]) begin
      if (cnt_reg[3:0] == 4'hf) begin
        o_serial_output_first  <= hold_first_reg[7];
        o_serial_output_second <= hold_second_reg[7];
        sh_first_reg           <= {hold_first_reg[6:0], 1'b1};
        sh_second_reg          <= {hold_second_reg[6:0], 1'b1};
      end else begin
        o_serial_output_first  <= sh_first_reg[7];
        o_serial_output_second <= sh_second_reg[7];
        sh_first_reg           <= {sh_first_reg[6:0], 1'b1};
        sh_second_reg          <= {sh_second_reg[6:0], 1'b1};
      end
    end
  end

  // host request decode
  assign host_loc = addr_s[4:0];
  assign vec_req  = (state_reg == tdpp_pkg::ST_IDLE) && !interrupt_acknowledge_n_n_s && !ds_n_s;
  assign host_req = (state_reg == tdpp_pkg::ST_IDLE) && !cs_n_s && !ds_n_s && interrupt_acknowledge_n_n_s;
  assign reg_wr   = host_req && addr_s[5] && !rw_s;
  assign reg_rd   = host_req && addr_s[5] && rw_s;
  assign rd_conflict    = slot && rx_ok && (rx_loc == host_loc);
  assign {wr_ext, wr_loc, wr_data} = bif.out_data;
  assign drain_conflict = slot && tx_ok && (tx_loc == wr_loc);

  // register read multiplexer
  always_comb begin
    unique case (host_loc)
      tdpp_pkg::REG_CTRL1:  reg_rd_val = ctrl1_reg;
      tdpp_pkg::REG_CTRL2:  reg_rd_val = ctrl2_reg;
      tdpp_pkg::REG_VECTOR: reg_rd_val = vector_reg;
      tdpp_pkg::REG_FLAGS1: reg_rd_val = flags_reg[0];
      tdpp_pkg::REG_FLAGS2: reg_rd_val = flags_reg[1];
      tdpp_pkg::REG_IMAGE1: reg_rd_val = image_reg[0];
      tdpp_pkg::REG_IMAGE2: reg_rd_val = image_reg[1];
      tdpp_pkg::REG_MASK1:  reg_rd_val = mask_reg[0];
      tdpp_pkg::REG_MASK2:  reg_rd_val = mask_reg[1];
      tdpp_pkg::REG_MATCH1: reg_rd_val = match_reg[0];
      tdpp_pkg::REG_MATCH2: reg_rd_val = match_reg[1];
      tdpp_pkg::REG_WATCH1: reg_rd_val = watch_reg[0];
      tdpp_pkg::REG_WATCH2: reg_rd_val = watch_reg[1];
      default:              reg_rd_val = '0;
    endcase
  end

  // host writable registers; reset bit of control one clears itself
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      ctrl1_reg  <= tdpp_pkg::REG_RESET;
      ctrl2_reg  <= tdpp_pkg::REG_RESET;
      vector_reg <= tdpp_pkg::REG_RESET;
      mask_reg   <= '{default: tdpp_pkg::REG_RESET};
      match_reg  <= '{default: tdpp_pkg::REG_RESET};
      watch_reg  <= '{default: tdpp_pkg::REG_RESET};
    end else begin
      ctrl1_reg[tdpp_pkg::C1_IRQ_RST] <= 1'b0;
      if (reg_wr) begin
        unique case (host_loc)
          tdpp_pkg::REG_CTRL1:  ctrl1_reg    <= data_s;
          tdpp_pkg::REG_CTRL2:  ctrl2_reg    <= data_s;
          tdpp_pkg::REG_VECTOR: vector_reg   <= data_s;
          tdpp_pkg::REG_MASK1:  mask_reg[0]  <= data_s;
          tdpp_pkg::REG_MASK2:  mask_reg[1]  <= data_s;
          tdpp_pkg::REG_MATCH1: match_reg[0] <= data_s;
          tdpp_pkg::REG_MATCH2: match_reg[1] <= data_s;
          tdpp_pkg::REG_WATCH1: watch_reg[0] <= data_s;
          tdpp_pkg::REG_WATCH2: watch_reg[1] <= data_s;
          default: ;
        endcase
      end
    end
  end

  // interrupt paths: flags sticky, image cleared by read, set wins
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      flags_reg <= '{default: tdpp_pkg::REG_RESET};
      image_reg <= '{default: tdpp_pkg::REG_RESET};
      prev_reg  <= '{default: tdpp_pkg::REG_RESET};
      irq_n_reg <= 1'b1;
    end else begin
      for (int k = 0; k < 2; k++) begin
        logic [7:0] hit;
        hit = mask_reg[k] & ~(rx_byte ^ match_reg[k]);
        if (ctrl1_reg[tdpp_pkg::C1_IRQ_MODE0 + k]) begin
          hit = hit & (rx_byte ^ prev_reg[k]);
        end
        if (ctrl1_reg[tdpp_pkg::C1_IRQ_RST]) begin
          flags_reg[k] <= '0;
          image_reg[k] <= '0;
        end else if (reg_rd && host_loc == tdpp_pkg::REG_IMAGE1 + 5'(k)) begin
          image_reg[k] <= '0;
        end
        if (slot && ch_now == watch_reg[k][4:0]) begin
          prev_reg[k] <= rx_byte;
          if (ctrl1_reg[tdpp_pkg::C1_IRQ_EN0 + k] && hit != '0) begin
            flags_reg[k] <= flags_reg[k] | hit;
            image_reg[k] <= rx_byte;
          end
        end
      end
      irq_n_reg <= (flags_reg[0] == '0) && (flags_reg[1] == '0);
    end
  end

  // posted host writes wait here; a serial slot fetching the same location blocks the drain
  assign bif.in_valid  = (state_reg == tdpp_pkg::ST_PUSH);
  assign bif.in_data   = {ctrl1_reg[tdpp_pkg::C1_ADDR_EXT], host_loc, data_s};
  assign bif.out_ready = !drain_conflict;

  tdpp_skid_buf #(.WIDTH(tdpp_pkg::WR_W), .DEPTH(tdpp_pkg::BUF_DEPTH)) u_wr_buf (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .bif       (bif)
  );

  // transmit ram write port
  always_ff @(posedge i_sys_clk) begin
    if (bif.out_valid && bif.out_ready) begin
      if (wr_ext) begin
        tx_second_ram[wr_loc] <= wr_data;
      end else begin
        tx_first_ram[wr_loc] <= wr_data;
      end
    end
  end

  // strobe handshake
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      state_reg <= tdpp_pkg::ST_IDLE;
      dout_reg  <= '0;
      oe_reg    <= 1'b0;
      ack_n_reg <= 1'b1;
    end else begin
      unique case (state_reg)
        tdpp_pkg::ST_IDLE: begin
          if (vec_req) begin
            dout_reg  <= vector_reg;
            oe_reg    <= 1'b1;
            ack_n_reg <= 1'b0;
            state_reg <= tdpp_pkg::ST_ACK;
          end else if (host_req && addr_s[5]) begin
            dout_reg  <= rw_s ? reg_rd_val : '0;
            oe_reg    <= rw_s;
            ack_n_reg <= 1'b0;
            state_reg <= tdpp_pkg::ST_ACK;
          end else if (host_req && rw_s && !rd_conflict) begin
            dout_reg  <= rx_ram[host_loc];
            oe_reg    <= 1'b1;
            ack_n_reg <= 1'b0;
            state_reg <= tdpp_pkg::ST_ACK;
          end else if (host_req && !rw_s) begin
            state_reg <= tdpp_pkg::ST_PUSH;
          end
        end
        tdpp_pkg::ST_PUSH: begin
          if (bif.in_ready) begin
            ack_n_reg <= 1'b0;
            state_reg <= tdpp_pkg::ST_ACK;
          end
        end
        tdpp_pkg::ST_ACK: begin
          if (ds_n_s) begin
            ack_n_reg <= 1'b1;
            oe_reg    <= 1'b0;
            state_reg <= tdpp_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end
  assign o_data                   = dout_reg;
  assign o_data_oe                = oe_reg;
  assign o_transfer_acknowledge_n = ack_n_reg;
  assign o_interrupt_request_n    = irq_n_reg;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  sequence s_ram_read;
    host_req && !addr_s[5] && rw_s && !rd_conflict;
  endsequence
  sequence s_reg_write(logic [4:0] off);
    reg_wr && host_loc == off;
  endsequence

  a_skip_all_ones: assert property (slot && mode24 && ch_next[1:0] == 2'b00
    |=> hold_first_reg == 8'hff && hold_second_reg == 8'hff) else $error("skip not ff");
  a_rx_read_data: assert property (s_ram_read |=> !o_transfer_acknowledge_n
    && o_data == $past(rx_ram[host_loc])) else $error("bad ram read");
  a_slot_wins: assert property (host_req && !addr_s[5] && rw_s && rd_conflict
    |=> o_transfer_acknowledge_n) else $error("ack during slot");
  a_ack_release: assert property (state_reg == tdpp_pkg::ST_ACK && ds_n_s
    |=> o_transfer_acknowledge_n && !o_data_oe) else $error("ack stuck");
  a_ctrl_write: assert property (s_reg_write(tdpp_pkg::REG_CTRL2)
    |=> ctrl2_reg == $past(data_s)) else $error("ctrl write lost");
  a_mask_write: assert property (s_reg_write(tdpp_pkg::REG_MASK2)
    |=> mask_reg[1] == $past(data_s)) else $error("mask write lost");
  a_unused_zero: assert property (reg_rd && host_loc == 5'h03
    |=> o_data == 8'h00 && o_data_oe) else $error("unused not zero");
  a_count_full: assert property (slot && !mode24 |-> rx_ok && tx_loc == ch_next)
    else $error("32 mode map");
  a_ext_second: assert property (bif.out_valid && bif.out_ready && wr_ext
    |=> tx_second_ram[$past(wr_loc)] == $past(wr_data)) else $error("ext write");
endmodule : tdpp_host_port

/* File: verification/tdpp_host_model.sv */
// host bus master model running strobe handshake cycles against the port
`timescale 1ns/10ps
module tdpp_host_model (
  // clock
  input  wire logic       i_sys_clk,
  // answer from the port
  input  wire logic [7:0] i_data,
  input  wire logic       i_ack_n,
  // strobe bus drive
  output logic            o_cs_n,
  output logic            o_rw,
  output logic            o_ds_n,
  output logic            o_interrupt_acknowledge_n_n,
  output logic [5:0]      o_addr,
  output logic [7:0]      o_wdata
);
  // idle bus levels at time zero
  initial begin
    o_cs_n   = 1'b1;
    o_rw     = 1'b1;
    o_ds_n   = 1'b1;
    o_interrupt_acknowledge_n_n = 1'b1;
    o_addr   = 6'h00;
    o_wdata  = 8'h00;
  end

  // one bus cycle; a vector fetch strobes with the acknowledge input instead of select
  task automatic access(input logic is_rd, input logic vec, input logic [5:0] a,
                        input logic [7:0] d, output logic [7:0] q);
    q = 8'hxx;
    @(negedge i_sys_clk);
    o_cs_n   <= vec;
    o_interrupt_acknowledge_n_n <= ~vec;
    o_rw     <= is_rd;
    o_addr   <= a;
    o_wdata  <= is_rd ? ~o_wdata : d;
    o_ds_n   <= 1'b0;
    // hold the request for as long as the port stretches the cycle
    for (int n = 0; n < 200; n++) begin
      @(negedge i_sys_clk);
      if (i_ack_n === 1'b0) break;
    end
    if (i_ack_n === 1'b0) q = i_data;
    @(posedge i_sys_clk);
    @(negedge i_sys_clk);
    o_cs_n   <= 1'b1;
    o_ds_n   <= 1'b1;
    o_interrupt_acknowledge_n_n <= 1'b1;
    o_wdata  <= ~o_wdata; // released lines do not keep the old value
    // no new cycle until the acknowledge has been withdrawn
    for (int n = 0; n < 200; n++) begin
      @(negedge i_sys_clk);
      if (i_ack_n === 1'b1) break;
    end
  endtask : access
endmodule : tdpp_host_model

/* File: verification/tdpp_host_port_tb.sv */
// self-checking bench for the tdm host port
`timescale 1ns/10ps
module tdpp_host_port_tb;
  logic       i_sys_clk = 1'b0;
  logic       i_rst     = 1'b1;
  logic       bclk      = 1'b1;
  logic       fp_n      = 1'b1;
  logic       sin       = 1'b0;
  logic       cs_n, rw, ds_n, interrupt_acknowledge_n_n, dout_oe, ack_n, irq_n, so1, so2;
  logic [5:0] addr;
  logic [7:0] wdata, dout, q;
  logic [8:0] bcnt      = 9'h000;
  logic [31:0] rnd      = 32'hcad1;
  logic [7:0] regm [32], tx1 [32], tx2 [32], rx_src [32];
  logic [7:0] cap1 [32], cap2 [32], snap1 [32], snap2 [32];
  int         fails = 0, comparisons = 0, dv = 0;
  event       frame_ev;

  // system clock
  always #10 i_sys_clk = ~i_sys_clk;

  tdpp_host_port i_dut (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_chip_select_n(cs_n),
    .i_read_write(rw), .i_data_strobe_n(ds_n), .i_interrupt_acknowledge_n(interrupt_acknowledge_n_n),
    .i_address(addr), .i_data(wdata), .o_data(dout), .o_data_oe(dout_oe),
    .o_transfer_acknowledge_n(ack_n), .o_interrupt_request_n(irq_n),
    .i_serial_bit_clock(bclk), .i_frame_pulse_n(fp_n), .i_serial_input_stream(sin),
    .o_serial_output_first(so1), .o_serial_output_second(so2));

  tdpp_host_model i_host (.i_sys_clk(i_sys_clk), .i_data(dout), .i_ack_n(ack_n),
    .o_cs_n(cs_n), .o_rw(rw), .o_ds_n(ds_n), .o_interrupt_acknowledge_n_n(interrupt_acknowledge_n_n), .o_addr(addr),
    .o_wdata(wdata));

  // bit clock, frame pulse, input bits and output capture, moved on the falling edge
  always @(negedge i_sys_clk) begin
    dv = (dv == 5) ? 0 : dv + 1;
    if (dv == 0) begin
      bclk = ~bclk;
      if (!bclk) begin
        bcnt = bcnt + 9'h001;
        if (!bcnt[0]) sin = rx_src[bcnt[8:4]][7 - bcnt[3:1]];
        if (bcnt == 9'h000) begin
          snap1 = cap1;
          snap2 = cap2;
          -> frame_ev;
        end
      end else begin
        fp_n = (bcnt != 9'h1ff);
        if (bcnt[0]) begin
          cap1[bcnt[8:4]][7 - bcnt[3:1]] = so1;
          cap2[bcnt[8:4]][7 - bcnt[3:1]] = so2;
        end
      end
    end
  end

  // random bytes; palindromes keep serial checks free of bit order
  function automatic logic [7:0] rb(input bit p);
    rnd = {rnd[30:0], rnd[31] ^ rnd[21] ^ rnd[1] ^ rnd[0]};
    return p ? {rnd[3:0], rnd[0], rnd[1], rnd[2], rnd[3]} : rnd[7:0];
  endfunction : rb

  // expected transmit byte of a serial channel from the bench ram model
  function automatic logic [7:0] txe(input bit s, input int ch);
    int l;
    l = regm[0][5] ? 3 * (ch / 4) + ch % 4 - 1 : ch;
    if (regm[0][5] && ch % 4 == 0) return 8'hff;
    return s ? tx2[l] : tx1[l];
  endfunction : txe

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // write through the host model and update the bench model
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] r;
    i_host.access(1'b0, 1'b0, a, d, r);
    if (!a[5]) begin
      if (regm[0][4]) tx2[a[4:0]] = d;
      else tx1[a[4:0]] = d;
    end else if (a[4:0] inside {[tdpp_pkg::REG_CTRL1:tdpp_pkg::REG_VECTOR],
                                [tdpp_pkg::REG_MASK1:tdpp_pkg::REG_WATCH2]}) begin
      regm[a[4:0]] = (a[4:0] == 5'h00) ? (d & 8'hbf) : d;
    end
  endtask : wr

  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    logic [7:0] r;
    i_host.access(1'b1, 1'b0, a, 8'h00, r);
    check($sformatf("read %h", a), r, e);
  endtask : rd

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : wrap_up

  // cut a hang short well past the planned run length
  initial begin
    repeat (90000) @(posedge i_sys_clk);
    fails++;
    wrap_up();
  end

  // main sequence
  initial begin
    for (int i = 0; i < 32; i++) begin
      regm[i] = 8'h00;
      rx_src[i] = rb(1'b1);
    end
    repeat (16) @(negedge i_sys_clk);
    i_rst = 1'b0;
    check("ack idle", {7'h00, ack_n}, 8'h01);
    check("irq idle", {7'h00, irq_n}, 8'h01);
    repeat (4) @(negedge i_sys_clk);
    for (int o = 0; o < 32; o++) rd({1'b1, 5'(o)}, 8'h00);
    $display("test reset values done");
    repeat (2) begin
      for (int o = 0; o < 32; o++) wr({1'b1, 5'(o)}, (o == 0) ? (rb(1'b0) & 8'h3c) : rb(1'b0));
      for (int o = 0; o < 32; o++) rd({1'b1, 5'(o)}, regm[o]);
    end
    i_host.access(1'b1, 1'b1, 6'h00, 8'h00, q);
    check("vector", q, regm[2]);
    check("oe released", {7'h00, dout_oe}, 8'h00);
    $display("test register access done");
    wr(6'h20, 8'h00);
    for (int l = 0; l < 32; l++) wr({1'b0, 5'(l)}, rb(1'b1));
    wr(6'h20, 8'h10);
    for (int l = 0; l < 32; l++) wr({1'b0, 5'(l)}, rb(1'b1));
    wr(6'h2c, 8'h05);
    wr(6'h2d, 8'h07);
    wr(6'h28, 8'hff);
    wr(6'h2a, rx_src[5]);
    wr(6'h20, 8'h11);
    repeat (3) @(frame_ev);
    for (int c = 0; c < 32; c++) begin
      check("first stream", snap1[c], txe(1'b0, c));
      check("second stream", snap2[c], txe(1'b1, c));
      rd({1'b0, 5'(c)}, rx_src[c]);
    end
    rd(6'h24, 8'hff);
    rd(6'h26, rx_src[5]);
    check("irq raised", {7'h00, irq_n}, 8'h00);
    wr(6'h20, 8'h40);
    rd(6'h24, 8'h00);
    check("irq cleared", {7'h00, irq_n}, 8'h01);
    // dynamic path two on steady data must stay quiet where static mode would fire
    wr(6'h29, 8'hff);
    wr(6'h2b, rx_src[7]);
    wr(6'h20, 8'h0a);
    repeat (2) @(frame_ev);
    rd(6'h25, 8'h00);
    rd(6'h27, 8'h00);
    check("irq dynamic", {7'h00, irq_n}, 8'h01);
    $display("test 32 channel done");
    wr(6'h20, 8'h20);
    for (int l = 0; l < 24; l++) wr({1'b0, 5'(l)}, rb(1'b1));
    wr(6'h20, 8'h30);
    for (int l = 0; l < 24; l++) wr({1'b0, 5'(l)}, rb(1'b1));
    repeat (3) @(frame_ev);
    for (int c = 0; c < 32; c++) begin
      check("first stream 24", snap1[c], txe(1'b0, c));
      check("second stream 24", snap2[c], txe(1'b1, c));
    end
    for (int l = 0; l < 24; l++) rd({1'b0, 5'(l)}, rx_src[4 * (l / 3) + l % 3 + 1]);
    $display("test 24 channel done");
    wrap_up();
  end
endmodule : tdpp_host_port_tb
